//--- verilog/acc_comparator_ctrl.sv
// Notes on behaviour
// R1: result is one when selected positive input exceeds selected negative input.
// R2: raw decision is synchronised; readable bit lags one to two clocks.
// R3: power-off bit 7 switches comparator off; writable any time.
// R4: software clears interrupt enable before changing power-off bit.
// R5: bandgap select bit 6 feeds bandgap to positive input, else pin.
// R6: event flag bit 4 sets on output change matching selected event mode.
// R7: interrupt requested when flag, enable bit 3 and global enable all set.
// R8: flag cleared by hardware when the comparator vector is executed.
// R9: writing one to flag clears it; writing zero leaves it.
// R10: capture-route bit 2 connects output to timer capture front end.
// R11: software also sets capture interrupt enable in timer mask.
// R12: mode bits 1:0 select toggle, reserved, falling, rising.
// R13: software clears interrupt enable before changing event mode.
// R14: neg-mux enable with converter off takes negative input from channel mux.
// R15: channel select 000 to 111 picks analog channel 0 to 7.
// R16: neg-mux off or converter on applies dedicated negative pin.
// R17: digital-input-disable bits gate pin buffers; pin bits read zero.
// R18: converter enable in control a turns converter on, blocks neg mux.
// R19: edge detection compares synchronised output with previous clock value.
// R20: reserved mode never sets the event flag.
//
// Added by the designer: register access over Avalon-MM and the register addresses.
module acc_comparator_ctrl
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Avalon-MM slave
  input  wire logic [4:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [3:0] avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]     avs_readdata,
  output logic            avs_waitrequest,
  // analog front end decision and selects
  input  wire logic       cmp_raw_decision,
  output logic            cmp_power_off,
  output logic            bandgap_positive_sel,
  output logic            neg_from_mux,
  output logic [2:0]      neg_channel,
  output logic            converter_enable,
  // pins
  input  wire logic       pos_input_pin_dig,
  input  wire logic       neg_input_pin_dig,
  output logic            pos_pin_buf_en,
  output logic            neg_pin_buf_en,
  output logic            pos_pin_read,
  output logic            neg_pin_read,
  // cpu side
  input  wire logic       global_irq_enable,
  input  wire logic       irq_vector_ack,
  output logic            cmp_irq,
  // timer capture
  output logic            capture_source_sel,
  output logic            capture_input
);
  logic [7:0] csb_q;
  logic [7:0] csa_q;
  logic [7:0] mux_q;
  logic [7:0] cmp_q;
  logic [7:0] did_q;
  logic       flag_q;
  logic       ack_q;
  logic       ack_d;
  logic [7:0] rd_d;
  logic       wr_lo;
  logic       hit_d;
  logic       event_hit;
  logic       out_sync;
  logic       out_prev;
  acc_mode_e  mode;

  acc_sync_if sif ();

  function automatic logic sel_hit(input logic [4:0] a, input logic [3:0] ofs,
                                   input logic [1:0] bank);
    sel_hit = (a[4:3] == bank[1:0]) && (a[2:0] == {ofs[3:2], 1'b0}) ||
              (a == {bank, ofs[3:2], 1'b0});
  endfunction

  function automatic logic at(input logic [4:0] a, input logic [4:0] byte_addr);
    at = (a == byte_addr);
  endfunction

  // one wait state: request answered on the edge after it is seen
  assign ack_d           = (avs_read || avs_write) && !ack_q;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_lo           = avs_write && ack_q && avs_byteenable[0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      csb_q <= ACC_RST_REG;
      csa_q <= ACC_RST_REG;
      mux_q <= ACC_RST_REG;
      cmp_q <= ACC_RST_REG;
      did_q <= ACC_RST_REG;
    end else if (wr_lo) begin
      if (at(avs_address, {1'b0, ACC_OFS_CSB})) begin
        csb_q <= avs_writedata[7:0];
      end
      if (at(avs_address, {1'b0, ACC_OFS_CSA})) begin
        csa_q <= avs_writedata[7:0]; // R18
      end
      if (at(avs_address, {1'b0, ACC_OFS_MUX})) begin
        mux_q <= avs_writedata[7:0];
      end
      if (at(avs_address, {1'b0, ACC_OFS_CMP})) begin
        cmp_q <= avs_writedata[7:0]; // R3
      end
      if (at(avs_address, ACC_ADDR_DID)) begin
        did_q <= avs_writedata[7:0];
      end
    end
  end

  // synchroniser and edge history
  assign sif.raw  = cmp_raw_decision && !cmp_q[ACC_B_POWER_OFF]; // R1 R3
  assign out_sync = sif.synced; // R2
  assign out_prev = sif.prev;

  acc_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .sif   (sif)
  );

  assign mode = acc_mode_e'(cmp_q[ACC_B_MODE_HI:ACC_B_MODE_LO]); // R12

  always_comb begin
    case (mode)
      ACC_MODE_TOGGLE:  hit_d = out_sync != out_prev; // R19
      ACC_MODE_FALLING: hit_d = out_prev && !out_sync;
      ACC_MODE_RISING:  hit_d = !out_prev && out_sync;
      ACC_MODE_RSVD:    hit_d = 1'b0; // R20
      default:          hit_d = 1'b0;
    endcase
  end
  assign event_hit = hit_d; // R6

  // event flag: set wins over either clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (event_hit) begin
      flag_q <= 1'b1; // R6
    end else if (irq_vector_ack) begin
      flag_q <= 1'b0; // R8
    end else if (wr_lo && at(avs_address, {1'b0, ACC_OFS_CMP}) &&
                 avs_writedata[ACC_B_EVENT_FLAG]) begin
      flag_q <= 1'b0; // R9
    end
  end

  assign cmp_irq = flag_q && cmp_q[ACC_B_IRQ_EN] && global_irq_enable; // R7

  // analog selects
  assign cmp_power_off        = cmp_q[ACC_B_POWER_OFF]; // R3
  assign bandgap_positive_sel = cmp_q[ACC_B_BANDGAP]; // R5
  assign converter_enable     = csa_q[ACC_B_CONV_EN]; // R18
  assign neg_from_mux = csb_q[ACC_B_NEG_MUX] && !csa_q[ACC_B_CONV_EN]; // R14 R16
  assign neg_channel  = mux_q[2:0]; // R15

  // capture routing
  assign capture_source_sel = cmp_q[ACC_B_CAPTURE]; // R10
  assign capture_input      = cmp_q[ACC_B_CAPTURE] && out_sync; // R10

  // pin digital buffers
  assign pos_pin_buf_en = !did_q[ACC_B_POS_DIG]; // R17
  assign neg_pin_buf_en = !did_q[ACC_B_NEG_DIG]; // R17
  assign pos_pin_read   = pos_input_pin_dig && !did_q[ACC_B_POS_DIG]; // R17
  assign neg_pin_read   = neg_input_pin_dig && !did_q[ACC_B_NEG_DIG]; // R17

  // read mux
  always_comb begin
    rd_d = 8'h00;
    if (at(avs_address, {1'b0, ACC_OFS_CSB})) begin
      rd_d = csb_q;
    end else if (at(avs_address, {1'b0, ACC_OFS_CSA})) begin
      rd_d = csa_q;
    end else if (at(avs_address, {1'b0, ACC_OFS_MUX})) begin
      rd_d = mux_q;
    end else if (at(avs_address, {1'b0, ACC_OFS_CMP})) begin
      rd_d = {cmp_q[7:6], out_sync, flag_q, cmp_q[3:0]};
    end else if (at(avs_address, ACC_ADDR_DID)) begin
      rd_d = did_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_readdata <= {24'h00_0000, rd_d};
    end
  end
endmodule

//--- verilog/acc_pkg.sv
package acc_pkg;
  // register byte offsets on the Avalon-MM slave
  localparam logic [3:0] ACC_OFS_CSB   = 4'h0;
  localparam logic [3:0] ACC_OFS_CSA   = 4'h4;
  localparam logic [3:0] ACC_OFS_MUX   = 4'h8;
  localparam logic [3:0] ACC_OFS_CMP   = 4'hC;
  localparam logic [3:0] ACC_OFS_DID   = 4'h0;
  localparam logic [1:0] ACC_BANK_CTL  = 2'h0;
  localparam logic [1:0] ACC_BANK_DID  = 2'h1;
  localparam logic [4:0] ACC_ADDR_DID  = 5'h10;

  // comparator control/status fields
  localparam int ACC_B_POWER_OFF  = 7;
  localparam int ACC_B_BANDGAP    = 6;
  localparam int ACC_B_OUT_SYNC   = 5;
  localparam int ACC_B_EVENT_FLAG = 4;
  localparam int ACC_B_IRQ_EN     = 3;
  localparam int ACC_B_CAPTURE    = 2;
  localparam int ACC_B_MODE_HI    = 1;
  localparam int ACC_B_MODE_LO    = 0;
  // converter control/status b and a
  localparam int ACC_B_NEG_MUX    = 6;
  localparam int ACC_B_CONV_EN    = 7;
  // digital input disable
  localparam int ACC_B_NEG_DIG    = 1;
  localparam int ACC_B_POS_DIG    = 0;

  localparam logic [7:0] ACC_RST_REG = 8'h00;

  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE  = 2'b00,
    ACC_MODE_RSVD    = 2'b01,
    ACC_MODE_FALLING = 2'b10,
    ACC_MODE_RISING  = 2'b11
  } acc_mode_e;
endpackage

//--- verilog/acc_sync_if.sv
interface acc_sync_if;
  logic raw;
  logic synced;
  logic prev;
  modport core (output raw, input synced, input prev);
  modport sync (input raw, output synced, output prev);
endinterface

//--- verilog/acc_sync.sv
module acc_sync
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // comparator level
  acc_sync_if.sync  sif
);
  logic stage1_q;
  logic stage2_q;
  logic prev_q;

  // two-flop synchroniser, then one-cycle history for edges
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      prev_q   <= 1'b0;
    end else begin
      stage1_q <= sif.raw;
      stage2_q <= stage1_q;
      prev_q   <= stage2_q;
    end
  end

  assign sif.synced = stage2_q;
  assign sif.prev   = prev_q;
endmodule

//--- testbench/acc_asserts.sv
module acc_asserts (
  input wire logic clk, rst_n, avs_read, avs_write, avs_waitrequest,
  input wire logic cmp_raw_decision, cmp_power_off, converter_enable, neg_from_mux,
  input wire logic pos_input_pin_dig, pos_pin_buf_en, pos_pin_read,
  input wire logic global_irq_enable, cmp_irq, capture_source_sel, capture_input
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wait_state_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1
    !avs_waitrequest) else $error("access not answered after one wait state");
  pin_gate_a: assert property (!pos_pin_buf_en |-> !pos_pin_read)
    else $error("disabled pin does not read zero");
  pin_pass_a: assert property (pos_pin_buf_en |-> pos_pin_read == pos_input_pin_dig)
    else $error("enabled pin does not follow its level");
  irq_gate_a: assert property (cmp_irq |-> global_irq_enable)
    else $error("request without global enable");
  mux_block_a: assert property (converter_enable |-> !neg_from_mux)
    else $error("channel mux used while converter on");
  route_gate_a: assert property (!capture_source_sel |-> !capture_input)
    else $error("capture fed while route is off");
  sync_track_a: assert property ((capture_source_sel && !cmp_power_off &&
    $stable(cmp_raw_decision))[*4] |-> capture_input == cmp_raw_decision)
    else $error("synchronised output lags more than two clocks");
  off_quiet_a: assert property (cmp_power_off[*3] |-> !capture_input)
    else $error("powered off comparator still drives output");
endmodule

bind acc_comparator_ctrl acc_asserts chk_u (.*);

//--- testbench/acc_analog_model.sv
module acc_analog_model #(
  parameter int BG_LEVEL = 600
) (
  input  wire logic        bandgap_positive_sel,
  input  wire logic        neg_from_mux,
  input  wire logic        cmp_power_off,
  input  wire logic [2:0]  neg_channel,
  input  wire logic [11:0] vp,
  input  wire logic [11:0] vn,
  output logic             cmp_raw_decision
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos_lvl, neg_lvl;
  always_comb begin
    pos_lvl = bandgap_positive_sel ? BG_LEVEL : int'(vp);
    neg_lvl = neg_from_mux ? 100 * int'(neg_channel) + 50 : int'(vn);
    cmp_raw_decision = !cmp_power_off && (pos_lvl > neg_lvl);
  end
endmodule

//--- testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acc_pkg::*;
  localparam logic [4:0] CSB = {1'b0, ACC_OFS_CSB}, CSA = {1'b0, ACC_OFS_CSA};
  localparam logic [4:0] MUX = {1'b0, ACC_OFS_MUX}, CMP = {1'b0, ACC_OFS_CMP};
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, cmp_raw_decision;
  logic cmp_power_off, bandgap_positive_sel, neg_from_mux, converter_enable;
  logic pos_input_pin_dig, neg_input_pin_dig, pos_pin_buf_en, neg_pin_buf_en;
  logic pos_pin_read, neg_pin_read, global_irq_enable, irq_vector_ack, cmp_irq;
  logic capture_source_sel, capture_input;
  logic [2:0] neg_channel;
  logic [3:0] avs_byteenable;
  logic [4:0] avs_address;
  logic [11:0] vp, vn;
  logic [31:0] avs_writedata, avs_readdata;
  int n_errors, comparisons;
  always #5 clk = ~clk;
  acc_comparator_ctrl dut_u (.*);
  acc_analog_model ana_u (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    logic wt;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    // look at waitrequest and read data while settled, before the edge that ends the access
    do begin
      @(negedge clk);
      wt = avs_waitrequest;
      r = avs_readdata;
      @(posedge clk);
    end while (wt);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(r, {24'h0, e});
  endtask
  task automatic t_regs();
    logic [4:0] regs [5] = '{CSB, CSA, MUX, CMP, ACC_ADDR_DID};
    foreach (regs[i]) rdc(regs[i], 8'h00);
    wr(5'h14, 8'hFF);
    rdc(5'h14, 8'h00);
    chk(pos_pin_buf_en, 1'b1);
    $display("regs done");
  endtask
  task automatic t_mux();
    wr(CMP, 8'h01);
    vp <= 12'd400;
    wr(CSB, 8'h40);
    for (int c = 0; c < 8; c++) begin
      wr(MUX, 8'(c));
      repeat (3) @(posedge clk);
      chk({neg_from_mux, neg_channel}, {1'b1, 3'(c)});
      rdc(CMP, {2'b0, 1'(c < 4), 5'h01});
    end
    wr(CSA, 8'h80);
    @(posedge clk);
    chk({neg_from_mux, converter_enable}, 2'b01);
    wr(CSA, 8'h00);
    wr(CSB, 8'h00);
    vp <= 12'd100;
    repeat (4) @(posedge clk);
    rdc(CMP, 8'h01);
    $display("mux done");
  endtask
  task automatic t_events();
    for (int m = 0; m < 4; m++) begin
      wr(CMP, 8'h10 | 8'(m));
      vp <= 12'd400;
      repeat (4) @(posedge clk);
      rdc(CMP, {3'b001, 1'(m == 0 || m == 3), 2'b0, 2'(m)});
      wr(CMP, 8'(m));
      rdc(CMP, {3'b001, 1'(m == 0 || m == 3), 2'b0, 2'(m)});
      wr(CMP, 8'h10 | 8'(m));
      vp <= 12'd100;
      repeat (4) @(posedge clk);
      rdc(CMP, {3'b0, 1'(m == 0 || m == 2), 2'b0, 2'(m)});
    end
    $display("events done");
  endtask
  task automatic t_irq();
    global_irq_enable <= 1'b1;
    wr(CMP, 8'h18);
    vp <= 12'd400;
    repeat (4) @(posedge clk);
    chk(cmp_irq, 1'b1);
    global_irq_enable <= 1'b0;
    @(posedge clk);
    chk(cmp_irq, 1'b0);
    global_irq_enable <= 1'b1;
    irq_vector_ack <= 1'b1;
    @(posedge clk);
    irq_vector_ack <= 1'b0;
    @(posedge clk);
    chk(cmp_irq, 1'b0);
    rdc(CMP, 8'h28);
    wr(CMP, 8'h10);
    vp <= 12'd100;
    repeat (4) @(posedge clk);
    chk(cmp_irq, 1'b0);
    $display("irq done");
  endtask
  task automatic t_misc();
    wr(CMP, 8'h55);
    repeat (4) @(posedge clk);
    chk({bandgap_positive_sel, capture_input}, 2'b11);
    wr(CMP, 8'h85);
    repeat (4) @(posedge clk);
    chk({cmp_power_off, capture_input}, 2'b10);
    rdc(CMP, 8'h85);
    pos_input_pin_dig <= 1'b1;
    neg_input_pin_dig <= 1'b1;
    wr(ACC_ADDR_DID, 8'h03);
    @(posedge clk);
    chk({pos_pin_buf_en, neg_pin_buf_en, pos_pin_read, neg_pin_read}, 4'h0);
    wr(ACC_ADDR_DID, 8'h00);
    @(posedge clk);
    chk({pos_pin_buf_en, neg_pin_buf_en, pos_pin_read, neg_pin_read}, 4'hF);
    $display("misc done");
  endtask
  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  initial begin
    {clk, rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {pos_input_pin_dig, neg_input_pin_dig, global_irq_enable, irq_vector_ack} = '0;
    avs_byteenable = 4'hF;
    vp = 12'd100;
    vn = 12'd300;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_mux();
    t_events();
    t_irq();
    t_misc();
    end_sim();
  end
endmodule
